/* File: src/ulpi_port_pkg.sv */
// Shared constants and carriers for the transceiver link-port block.
// Assumes one core clock (clk_in) and one interface clock from the on-chip PLL.
package ulpi_port_pkg;

  // Bus geometry: bit 7 is the most significant bit of each byte
  localparam int DATA_W = 8;
  localparam logic [DATA_W-1:0] BUS_IDLE = 8'h00;

  // Clock rates in MHz
  localparam int SYS_CLK_MHZ = 10;
  localparam int INTERFACE_CLK_MHZ = 60;
  localparam int REF_CLK_MHZ = 13;

  // Reference watchdog: two reference periods in interface cycles, rounded up
  localparam int REF_WATCH_CYCLES =
    2 * ((INTERFACE_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ);
  localparam logic [3:0] REF_WATCH_MAX = 4'(REF_WATCH_CYCLES);
  localparam logic [3:0] REF_CNT_RESET = 4'h0;

  // One byte of a stream plus its end marker
  typedef struct packed {
    logic last;
    logic [DATA_W-1:0] data;
  } byte_msg_type;

  localparam byte_msg_type MSG_RESET = 9'h000;

  // Link-side bus ownership states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_TURN_UP = 5'h02,
    ST_SEND    = 5'h04,
    ST_TURN_DN = 5'h08,
    ST_RECV    = 5'h10
  } link_state_type;

endpackage

/* File: src/ulpi_phy_port.sv */
// Transceiver side of the low-pin-count link port: bus direction, throttle and stop.
// Assumes link_clk_in is the 60 MHz PLL output derived from the 13 MHz reference,
// and the pad ring resolves each two-way pin from the *_oe_out enables.
//
// What this block does
// - The interface clock is sent out and every link-port output launches on its rising edge.
// - The data bus is eight bits wide, two-way, with bit 7 as the most significant bit.
// - NXT is active high and marks the cycle in which the byte on the bus is accepted.
// - With data for the link, the transceiver raises DIR first and then drives the bus.
// - With nothing to deliver, DIR stays low, the bus is released and watched for commands.
// - STP comes the cycle after the final byte, which the transceiver treats as the last one.
// - While the reset pin is low every digital output floats; when high, with rst_n_in high and a live reference, the port runs.
// - Commands and status travel in-band on the shared bus over twelve signals in all.
`timescale 1ns/10ps

module ulpi_phy_port import ulpi_port_pkg::*; (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic link_clk_in,
  input wire logic reference_clock_in,
  input wire logic reset_low_input_in,
  output logic interface_clock_out,
  output logic clock_oe_out,
  output logic dir_out,
  output logic dir_oe_out,
  output logic nxt_out,
  output logic nxt_oe_out,
  input wire logic stp_in,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_out,
  input wire byte_msg_type dlv_msg_in,
  input wire logic dlv_valid_in,
  output logic dlv_ready_out,
  output byte_msg_type rcv_msg_out,
  output logic rcv_valid_out,
  input wire logic rcv_ready_in,
  output logic link_up_out
);

  // Core domain state
  logic rl_s1_q, rl_s2_q, up_s1_q, up_s2_q;
  logic dlv_req_q, dlv_ready_q, dlv_ack_s1_q, dlv_ack_s2_q;
  byte_msg_type dlv_msg_q;
  logic rcv_req_s1_q, rcv_req_s2_q, rcv_ack_q, rcv_valid_q;
  byte_msg_type rcv_out_q;
  logic core_run;

  // Link domain state
  logic lr_s1_q, lr_s2_q, pin_oe_q, link_active_q, clk_gate_q;
  logic lp_s1_q, lp_s2_q, link_run;
  logic ref_s1_q, ref_s2_q, ref_s3_q, ref_ok_q;
  logic [3:0] ref_cnt_q;
  link_state_type state_q;
  logic dir_q, nxt_q, data_oe_q, sent_last_q;
  logic [DATA_W-1:0] data_q, stage_q;
  logic stage_full_q, end_pend_q;
  logic dlv_req_s1_q, dlv_req_s2_q, dlv_ack_q, dlv_pend;
  logic rcv_req_q, rcv_ack_s1_q, rcv_ack_s2_q, mbox_free, rx_can_take;
  byte_msg_type rcv_msg_q;

  // Reset pin and power-on reset held together; pin is asynchronous to both clocks
  always_ff @(posedge clk_in) begin
    rl_s1_q <= reset_low_input_in;
    rl_s2_q <= rl_s1_q;
  end
  assign core_run = rst_n_in & rl_s2_q;

  // Same two sources, each through its own pair so no gate sits ahead of a first flop
  always_ff @(posedge link_clk_in) begin
    lr_s1_q <= reset_low_input_in;
    lr_s2_q <= lr_s1_q;
    lp_s1_q <= rst_n_in;
    lp_s2_q <= lp_s1_q;
    pin_oe_q <= link_run;
  end
  assign link_run = lr_s2_q & lp_s2_q;

  // Reference watchdog; the clock only goes out while the reference toggles
  always_ff @(posedge link_clk_in) begin
    ref_s1_q <= reference_clock_in;
    ref_s2_q <= ref_s1_q;
    ref_s3_q <= ref_s2_q;
    if (!link_run) begin
      ref_cnt_q <= REF_CNT_RESET;
      ref_ok_q <= 1'b0;
    end else if (ref_s2_q ^ ref_s3_q) begin
      ref_cnt_q <= REF_CNT_RESET;
      ref_ok_q <= 1'b1;
    end else if (ref_cnt_q == REF_WATCH_MAX) begin
      ref_ok_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_cnt_q + 4'h1;
    end
  end

  // Port runs only out of suspend and with a live reference
  always_ff @(posedge link_clk_in) begin
    if (!link_run) begin
      link_active_q <= 1'b0;
    end else begin
      link_active_q <= ref_ok_q;
    end
  end

  // Gate updated on the falling edge so the outgoing clock never glitches
  always_ff @(negedge link_clk_in) begin
    clk_gate_q <= link_active_q;
  end
  assign interface_clock_out = link_clk_in & clk_gate_q;

  // Crossing flops for both mailboxes
  always_ff @(posedge link_clk_in) begin
    dlv_req_s1_q <= dlv_req_q;
    dlv_req_s2_q <= dlv_req_s1_q;
    rcv_ack_s1_q <= rcv_ack_q;
    rcv_ack_s2_q <= rcv_ack_s1_q;
  end
  assign dlv_pend = dlv_req_s2_q != dlv_ack_q;
  assign mbox_free = rcv_req_q == rcv_ack_s2_q;
  assign rx_can_take = mbox_free & ~end_pend_q;

  // Bus ownership, throttle and turnarounds, all launched on the rising edge
  always_ff @(posedge link_clk_in) begin
    if (!link_active_q) begin
      state_q <= ST_IDLE;
      dir_q <= 1'b0;
      nxt_q <= 1'b0;
      data_oe_q <= 1'b0;
      data_q <= BUS_IDLE;
      dlv_ack_q <= 1'b0;
      sent_last_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          nxt_q <= 1'b0;
          if (dlv_pend && !end_pend_q) begin
            dir_q <= 1'b1;
            state_q <= ST_TURN_UP;
          end else if (data_in != BUS_IDLE && rx_can_take) begin
            nxt_q <= 1'b1;
            state_q <= ST_RECV;
          end
        end
        ST_TURN_UP: begin
          // Turnaround cycle lets the link let go of the bus
          data_oe_q <= 1'b1;
          data_q <= dlv_msg_q.data;
          sent_last_q <= dlv_msg_q.last;
          nxt_q <= 1'b1;
          dlv_ack_q <= dlv_req_s2_q;
          state_q <= ST_SEND;
        end
        ST_SEND: begin
          if (sent_last_q) begin
            dir_q <= 1'b0;
            data_oe_q <= 1'b0;
            nxt_q <= 1'b0;
            state_q <= ST_TURN_DN;
          end else if (dlv_pend) begin
            data_q <= dlv_msg_q.data;
            sent_last_q <= dlv_msg_q.last;
            nxt_q <= 1'b1;
            dlv_ack_q <= dlv_req_s2_q;
          end else begin
            nxt_q <= 1'b0; // Waiting on the core; bus holds the old byte
          end
        end
        ST_TURN_DN: begin
          state_q <= ST_IDLE;
        end
        ST_RECV: begin
          if (stp_in) begin
            nxt_q <= 1'b0;
            state_q <= ST_IDLE;
          end else begin
            nxt_q <= ~nxt_q & rx_can_take;
          end
        end
        default: begin
          state_q <= ST_IDLE;
          dir_q <= 1'b0;
          data_oe_q <= 1'b0;
          nxt_q <= 1'b0;
        end
      endcase
    end
  end

  // Bytes from the link: one held back so STP can still mark it last
  always_ff @(posedge link_clk_in) begin
    if (!link_active_q) begin
      stage_q <= BUS_IDLE;
      stage_full_q <= 1'b0;
      end_pend_q <= 1'b0;
      rcv_req_q <= 1'b0;
      rcv_msg_q <= MSG_RESET;
    end else if (state_q == ST_RECV && nxt_q && !stp_in) begin
      stage_q <= data_in;
      stage_full_q <= 1'b1;
      if (stage_full_q) begin
        rcv_msg_q <= '{last: 1'b0, data: stage_q};
        rcv_req_q <= ~rcv_req_q;
      end
    end else if (state_q == ST_RECV && stp_in) begin
      end_pend_q <= stage_full_q;
    end else if (end_pend_q && mbox_free) begin
      rcv_msg_q <= '{last: 1'b1, data: stage_q};
      rcv_req_q <= ~rcv_req_q;
      end_pend_q <= 1'b0;
      stage_full_q <= 1'b0;
    end
  end

  // Core side: accept one byte to deliver, free again once the link acknowledges
  always_ff @(posedge clk_in) begin
    dlv_ack_s1_q <= dlv_ack_q;
    dlv_ack_s2_q <= dlv_ack_s1_q;
    if (!core_run) begin
      dlv_req_q <= 1'b0;
      dlv_ready_q <= 1'b0;
      dlv_msg_q <= MSG_RESET;
    end else if (dlv_valid_in && dlv_ready_q) begin
      dlv_msg_q <= dlv_msg_in;
      dlv_req_q <= ~dlv_req_q;
      dlv_ready_q <= 1'b0;
    end else begin
      dlv_ready_q <= dlv_req_q == dlv_ack_s2_q;
    end
  end

  // Core side: present received bytes until taken
  always_ff @(posedge clk_in) begin
    rcv_req_s1_q <= rcv_req_q;
    rcv_req_s2_q <= rcv_req_s1_q;
    up_s1_q <= link_active_q;
    up_s2_q <= up_s1_q;
    if (!core_run) begin
      rcv_valid_q <= 1'b0;
      rcv_ack_q <= 1'b0;
      rcv_out_q <= MSG_RESET;
    end else if (rcv_valid_q) begin
      rcv_valid_q <= ~rcv_ready_in;
    end else if (up_s2_q && rcv_req_s2_q != rcv_ack_q) begin
      // Link side resets first on suspend; its toggle drop must not look like a byte
      rcv_out_q <= rcv_msg_q;
      rcv_valid_q <= 1'b1;
      rcv_ack_q <= ~rcv_ack_q;
    end
  end

  // Every output straight from a flop, except the gated clock
  assign clock_oe_out = pin_oe_q;
  assign dir_out = dir_q;
  assign dir_oe_out = pin_oe_q;
  assign nxt_out = nxt_q;
  assign nxt_oe_out = pin_oe_q;
  assign data_out = data_q;
  assign data_oe_out = data_oe_q;
  assign dlv_ready_out = dlv_ready_q;
  assign rcv_msg_out = rcv_out_q;
  assign rcv_valid_out = rcv_valid_q;
  assign link_up_out = up_s2_q;

  a_dir_before_drive:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      $rose(dir_q) |-> !data_oe_q ##1 data_oe_q)
    else $error("bus driven without a turnaround after DIR rose");

  a_drive_needs_dir:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      !dir_q |-> !data_oe_q)
    else $error("bus driven while DIR low");

  a_cmd_gets_nxt:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      (state_q == ST_IDLE && !dlv_pend && data_in != BUS_IDLE && rx_can_take)
      |=> nxt_q && state_q == ST_RECV)
    else $error("command on idle bus not accepted");

  a_nxt_single:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      (state_q == ST_RECV && nxt_q) |=> !nxt_q)
    else $error("receive throttle held two cycles");

  a_nxt_captures:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      (state_q == ST_RECV && nxt_q && !stp_in) |=>
      stage_full_q && stage_q == $past(data_in))
    else $error("accepted byte not captured");

  a_stop_marks_last:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      (state_q == ST_RECV && stp_in && stage_full_q) |=>
      end_pend_q && state_q == ST_IDLE)
    else $error("stop did not close the stream");

  a_send_byte_order:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      $rose(data_oe_q) |-> nxt_q && data_q == $past(dlv_msg_q.data))
    else $error("first delivered byte wrong");

  a_last_releases:
    assert property (@(posedge link_clk_in) disable iff (!link_active_q)
      (state_q == ST_SEND && sent_last_q) |=> !dir_q ##1 state_q == ST_IDLE)
    else $error("bus not released after last byte");

  a_suspend_floats:
    assert property (@(posedge link_clk_in)
      (!link_run && !link_active_q) |=> !pin_oe_q && !data_oe_q)
    else $error("pins driven during suspend");

endmodule

/* File: tb/ulpi_link_model.sv */
// Link controller stand-in that sends one command stream to the transceiver.
// Assumes the bench resolves the bus and feeds back DIR and NXT as seen on the pins.
`timescale 1ns/10ps
module ulpi_link_model import ulpi_port_pkg::*; (
  input wire logic clk_in,
  input wire logic dir_in,
  input wire logic nxt_in,
  input wire logic go_in,
  input wire logic [DATA_W-1:0] first_in,
  input wire logic [3:0] count_in,
  output logic [DATA_W-1:0] data_out,
  output logic oe_out,
  output logic stp_out
);
  logic busy_q = 1'b0;
  logic [3:0] idx_q = 4'h0;
  logic [DATA_W-1:0] byte_q = BUS_IDLE;
  logic nxt_s;
  logic dir_s;
  logic go_s;
  logic stp_q = 1'b0;
  logic stp_d;
  // Never fight the transceiver for the bus
  assign oe_out = ~dir_in;
  assign data_out = byte_q;
  assign stp_out = stp_q;
  // Sample at the edge, then move just after it like a real link
  always @(posedge clk_in) begin
    nxt_s = nxt_in;
    dir_s = dir_in;
    go_s = go_in;
    #1;
    stp_d = 1'b0;
    if (busy_q && nxt_s && !dir_s) begin
      if (idx_q == count_in - 4'h1) begin
        busy_q = 1'b0;
        byte_q = BUS_IDLE;
        stp_d = 1'b1;
      end else begin
        idx_q = idx_q + 4'h1;
        byte_q = first_in + 8'(idx_q);
      end
    end else if (go_s && !busy_q && !dir_s) begin
      busy_q = 1'b1;
      idx_q = 4'h0;
      byte_q = first_in;
    end
    // One write per edge, so stop never glitches
    stp_q = stp_d;
  end
endmodule

/* File: tb/ulpi_phy_port_test.sv */
// Self-checking bench for the transceiver link-port block.
// Assumes the link model is compiled first; all clocks are made here.
`timescale 1ns/10ps
module ulpi_phy_port_test import ulpi_port_pkg::*; ;
  logic clk = 0, lclk = 0, rclk = 0, rst_n = 0, pin_n = 1, go = 0, dlv_valid = 0;
  logic stp, link_oe, dlv_ready, rcv_valid, link_up, ifclk, ck_oe, dir, dir_oe, nxt, nxt_oe, d_oe;
  logic [7:0] bus, link_data, d_out, last_q = 8'h00;
  logic [7:0] dq[$];
  byte_msg_type rq[$];
  byte_msg_type dlv_msg = MSG_RESET, rcv_msg;
  byte_msg_type rows[4] = '{9'h0A5, 9'h03C, 9'h181, 9'h17E};
  int err_total = 0, total_checks = 0;
  // Core, interface and 13 MHz reference clocks, unrelated in phase
  always #50 clk = ~clk;
  always #3 lclk = ~lclk;
  always #38.46 rclk = ~rclk;
  // Undriven bus shows the inverse of its last level
  assign bus = d_oe ? d_out : (link_oe ? link_data : ~last_q);
  ulpi_phy_port i_ulpi_phy_port (.clk_in(clk), .rst_n_in(rst_n), .link_clk_in(lclk),
    .reference_clock_in(rclk), .reset_low_input_in(pin_n), .interface_clock_out(ifclk),
    .clock_oe_out(ck_oe), .dir_out(dir), .dir_oe_out(dir_oe), .nxt_out(nxt),
    .nxt_oe_out(nxt_oe), .stp_in(stp), .data_in(bus), .data_out(d_out), .data_oe_out(d_oe),
    .dlv_msg_in(dlv_msg), .dlv_valid_in(dlv_valid), .dlv_ready_out(dlv_ready),
    .rcv_msg_out(rcv_msg), .rcv_valid_out(rcv_valid), .rcv_ready_in(1'b1),
    .link_up_out(link_up));
  ulpi_link_model i_ulpi_link_model (.clk_in(ifclk), .dir_in(dir), .nxt_in(nxt), .go_in(go),
    .first_in(8'h41), .count_in(4'h3), .data_out(link_data), .oe_out(link_oe), .stp_out(stp));
  task chk(string n, logic [8:0] e, logic [8:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Link-side monitor: accepted bytes and bus ownership
  always @(posedge lclk) begin
    last_q <= bus;
    if (dir === 1'b1 && nxt === 1'b1 && d_oe === 1'b1) dq.push_back(d_out);
    if (rst_n && d_oe !== 1'b0 && dir !== 1'b1) chk("bus owner", 9'h0, 9'h1);
  end
  // Core receive side, always ready
  always @(posedge clk) if (rcv_valid === 1'b1) rq.push_back(rcv_msg);
  // Hang guard, far beyond the expected run
  initial begin
    #400000;
    err_total++;
    end_of_test;
  end
  task wait_up;
    for (int k = 0; k < 200 && link_up !== 1'b1; k++) @(posedge clk);
    chk("link up", 9'h1, 9'(link_up));
  endtask
  initial begin
    repeat (9) @(posedge clk);
    chk("oe in reset", 9'h0, 9'({ck_oe, dir_oe, nxt_oe, d_oe}));
    @(posedge clk);
    #1 rst_n = 1;
    wait_up;
    @(posedge lclk);
    #0.5 chk("clock out", 9'h1, 9'(ifclk));
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      for (int k = 0; k < 100 && dlv_ready !== 1'b1; k++) @(posedge clk);
      #1 dlv_msg = rows[i];
      dlv_valid = 1;
      @(posedge clk);
      #1 dlv_valid = 0;
      for (int k = 0; k < 300 && dq.size() == 0; k++) @(posedge lclk);
      chk("delivered", 9'(rows[i].data), (dq.size() > 0) ? 9'(dq.pop_front()) : 9'h1FF);
      if (rows[i].last) begin
        repeat (3) @(posedge lclk);
        chk("dir after last", 9'h0, 9'(dir));
      end
    end
    $display("test deliver done");
    @(posedge lclk);
    #1 go = 1;
    @(posedge lclk);
    #1 go = 0;
    for (int k = 0; k < 500 && rq.size() < 3; k++) @(posedge clk);
    chk("received count", 9'h3, 9'(rq.size()));
    for (int j = 0; j < 3 && j < rq.size(); j++) begin
      chk("received", {j == 2, 8'h41 + 8'(j)}, rq[j]);
    end
    $display("test receive done");
    #1 pin_n = 0;
    repeat (5) @(posedge clk);
    chk("oe suspended", 9'h0, 9'({ck_oe, dir_oe, nxt_oe, d_oe, dlv_ready}));
    #1 pin_n = 1;
    wait_up;
    chk("no byte on suspend", 9'h3, 9'(rq.size()));
    $display("test reset pin done");
    end_of_test;
  end
endmodule
